// ===== rtl/mpw_pkg.sv
package mpw_pkg;
  localparam int NUM_AXES = 4;
  localparam int DATA_W   = 16;
  localparam int CODE_W   = 8;

  // Command codes
  localparam logic [7:0] CMD_JERK      = 8'h00;
  localparam logic [7:0] CMD_DECEL_JRK = 8'h01;
  localparam logic [7:0] CMD_ACCEL     = 8'h02;
  localparam logic [7:0] CMD_DECEL     = 8'h03;
  localparam logic [7:0] CMD_INIT_SPD  = 8'h04;
  localparam logic [7:0] CMD_DRV_SPD   = 8'h05;
  localparam logic [7:0] CMD_NOP       = 8'h1f;
  localparam logic [7:0] CMD_RD_CUR_AC = 8'h33;
  localparam logic [7:0] CMD_RD_AC     = 8'h43;
  localparam logic [7:0] CMD_RD_SV     = 8'h44;
  localparam logic [7:0] CMD_SPD_INC   = 8'h70;
  localparam logic [7:0] CMD_SPD_DEC   = 8'h71;
  localparam logic [7:0] CMD_DEV_CLR   = 8'h72;
  localparam logic [7:0] CMD_TMR_START = 8'h73;
  localparam logic [7:0] CMD_TMR_STOP  = 8'h74;
  localparam logic [7:0] CMD_SPLIT_ON  = 8'h75;
  localparam logic [7:0] CMD_SPLIT_OFF = 8'h76;
  localparam logic [7:0] CMD_HOLD      = 8'h77;
  localparam logic [7:0] CMD_HOLD_REL  = 8'h78;
  localparam logic [7:0] CMD_ERR_CLR   = 8'h79;
  localparam logic [7:0] CMD_PAGE0     = 8'h7a;
  localparam logic [7:0] CMD_PAGE1     = 8'h7b;
  localparam logic [7:0] CMD_FP_CLR    = 8'h7c;
  localparam logic [7:0] CMD_RESET     = 8'hff;

  // Command word layout: axis select in [11:8], code in [7:0]
  localparam int CMD_AXIS_LSB = 8;

  // Host hold-off after a command: 125 ns at 100 MHz, rounded up
  localparam int HOLDOFF_NS     = 125;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Accel maximum recommended for pure S-curve
  localparam logic [31:0] ACCEL_MAX = 32'h1fffffff;

  // Rate of speed ramp per cycle when following a new drive speed
  localparam logic [31:0] RAMP_STEP = 32'h00000001;

  typedef enum logic [1:0] {
    MPW_SEL_LOW,
    MPW_SEL_HIGH,
    MPW_SEL_CMD
  } mpw_sel_t;
endpackage : mpw_pkg

// ===== rtl/mpw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mpw_if;
  import mpw_pkg::*;
  logic              wr;
  mpw_sel_t          sel;
  logic [DATA_W-1:0] wdata;
  logic [31:0]       rdata;
  logic              rvalid;

  modport dev  (input wr, sel, wdata, output rdata, rvalid);
  modport host (output wr, sel, wdata, input rdata, rvalid);
endinterface : mpw_if
`default_nettype wire

// ===== rtl/mpw_device.sv
// Contract
// - 70h/71h speed up/down, 72h deviation clear pulse
// - 73h/74h timer, 75h/76h split pulse start/stop
// - 77h holds drive start, 78h releases hold
// - 79h clear errors, 7Ah/7Bh page, 7Ch clear
// - Host writes only listed codes, incl 1Fh, FFh
// - Multi-axis write loads every selected axis
// - Data low/high words, then command word executes
// - Data binary two's complement, host keeps range
// - Host waits 125 ns after each command
// - Only accel offset, maxima defined at reset
// - 00h loads jerk, also decel when symmetric
// - 01h decel rate, ignored when symmetric
// - 02h loads accel, also decel when symmetric
// - Host sets accel maximum for pure S-curve
// - 03h loads decel for nonsymmetric profiles
// - 04h loads initial speed, ramp start/end
// - Host keeps initial speed above sqrt bounds
// - 05h loads drive speed plateau
// - Drive below initial speed: constant speed
// - New drive speed while driving: ramp then hold
// - Units assume 16 MHz system clock; the code is timed for a 100 MHz clock
// - Read 33h current accel, 43h accel, 44h initial
`timescale 1ns/1ps
`default_nettype none
module mpw_device
  import mpw_pkg::*;
#(
  parameter int          AXES        = NUM_AXES,
  parameter logic [31:0] ACCEL_OFS_RST = 32'h00000008,
  parameter logic [31:0] POS_MAX_RST   = 32'hffffffff
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  mpw_if.dev                   bus,
  input  wire logic            nonsymmetric_profile_select,
  input  wire logic [AXES-1:0] driving,
  output logic [AXES-1:0]      speed_inc,
  output logic [AXES-1:0]      speed_dec,
  output logic [AXES-1:0]      deviation_clear,
  output logic [AXES-1:0]      timer_run,
  output logic [AXES-1:0]      split_run,
  output logic [AXES-1:0]      start_hold,
  output logic [AXES-1:0]      error_clear,
  output logic [AXES-1:0]      finish_max_clear,
  output logic                 status_three_page,
  output logic [31:0]          jerk_value       [AXES],
  output logic [31:0]          decel_jerk_eff   [AXES],
  output logic [31:0]          accel_eff        [AXES],
  output logic [31:0]          decel_eff        [AXES],
  output logic [31:0]          initial_speed_value [AXES],
  output logic [31:0]          target_speed     [AXES],
  output logic [31:0]          current_speed    [AXES],
  output logic [31:0]          accel_offset_value,
  output logic [31:0]          logical_pos_max
);
  typedef struct packed {
    logic [DATA_W-1:0]        data_low;
    logic [DATA_W-1:0]        data_high;
    logic [AXES-1:0]          inc;
    logic [AXES-1:0]          dec;
    logic [AXES-1:0]          dev_clr;
    logic [AXES-1:0]          tmr;
    logic [AXES-1:0]          split;
    logic [AXES-1:0]          hold;
    logic [AXES-1:0]          err_clr;
    logic [AXES-1:0]          fp_clr;
    logic                     page;
    logic [AXES-1:0][31:0]    jerk;
    logic [AXES-1:0][31:0]    djerk;
    logic [AXES-1:0][31:0]    accel;
    logic [AXES-1:0][31:0]    decel;
    logic [AXES-1:0][31:0]    isv;
    logic [AXES-1:0][31:0]    dsv;
    logic [AXES-1:0][31:0]    cur;
    logic [AXES-1:0][31:0]    cur_acc;
    logic [AXES-1:0][31:0]    djerk_mux;
    logic [AXES-1:0][31:0]    decel_mux;
    logic [31:0]              ao;
    logic [31:0]              lx;
    logic [31:0]              rdata;
    logic                     rvalid;
  } mpw_dev_st_t;

  mpw_dev_st_t st;
  mpw_dev_st_t next_st;

  // Lowest selected axis answers a read
  function automatic int mpw_first_axis(input logic [AXES-1:0] m);
    int r;
    r = 0;
    for (int i = AXES - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = i;
      end
    end
    return r;
  endfunction : mpw_first_axis

  logic [AXES-1:0] cmd_axes;
  logic [7:0]      cmd_code;
  logic [31:0]     word32;
  logic            cmd_go;
  assign cmd_axes = bus.wdata[CMD_AXIS_LSB +: AXES];
  assign cmd_code = bus.wdata[CODE_W-1:0];
  assign word32   = {st.data_high, st.data_low};
  assign cmd_go   = bus.wr && bus.sel == MPW_SEL_CMD;

  always_comb begin
    int          ra;
    logic [31:0] goal;
    ra = 0;
    goal = '0;
    next_st = st;
    next_st.inc = '0;
    next_st.dec = '0;
    next_st.dev_clr = '0;
    next_st.err_clr = '0;
    next_st.fp_clr = '0;
    next_st.rvalid = 1'b0;
    if (bus.wr && bus.sel == MPW_SEL_LOW) begin
      next_st.data_low = bus.wdata;
    end
    if (bus.wr && bus.sel == MPW_SEL_HIGH) begin
      next_st.data_high = bus.wdata;
    end
    // Speed follower runs every cycle; a new drive speed written mid-drive is chased
    for (int a = 0; a < AXES; a++) begin
      goal = (st.dsv[a] < st.isv[a]) ? st.isv[a] : st.dsv[a];
      if (!driving[a]) begin
        next_st.cur[a] = st.isv[a];
        next_st.cur_acc[a] = '0;
      end else if (st.dsv[a] < st.isv[a]) begin
        next_st.cur[a] = st.isv[a];
        next_st.cur_acc[a] = '0;
      end else if (st.cur[a] < goal) begin
        next_st.cur[a] = st.cur[a] + RAMP_STEP;
        next_st.cur_acc[a] = st.accel[a];
      end else if (st.cur[a] > goal) begin
        next_st.cur[a] = st.cur[a] - RAMP_STEP;
        next_st.cur_acc[a] = nonsymmetric_profile_select ? st.decel[a] : st.accel[a];
      end else begin
        next_st.cur_acc[a] = '0;
      end
    end
    if (cmd_go) begin
      unique case (cmd_code)
        CMD_SPD_INC:   next_st.inc = cmd_axes;
        CMD_SPD_DEC:   next_st.dec = cmd_axes;
        CMD_DEV_CLR:   next_st.dev_clr = cmd_axes;
        CMD_TMR_START: next_st.tmr = st.tmr | cmd_axes;
        CMD_TMR_STOP:  next_st.tmr = st.tmr & ~cmd_axes;
        CMD_SPLIT_ON:  next_st.split = st.split | cmd_axes;
        CMD_SPLIT_OFF: next_st.split = st.split & ~cmd_axes;
        CMD_HOLD:      next_st.hold = st.hold | cmd_axes;
        CMD_HOLD_REL:  next_st.hold = st.hold & ~cmd_axes;
        CMD_ERR_CLR:   next_st.err_clr = cmd_axes;
        CMD_PAGE0:     next_st.page = 1'b0;
        CMD_PAGE1:     next_st.page = 1'b1;
        CMD_FP_CLR:    next_st.fp_clr = cmd_axes;
        CMD_RD_CUR_AC, CMD_RD_AC, CMD_RD_SV: begin
          ra = mpw_first_axis(cmd_axes);
          next_st.rvalid = 1'b1;
          if (cmd_code == CMD_RD_CUR_AC) begin
            next_st.rdata = st.cur_acc[ra];
          end else if (cmd_code == CMD_RD_AC) begin
            next_st.rdata = st.accel[ra];
          end else begin
            next_st.rdata = st.isv[ra];
          end
        end
        default: begin
          // Parameter loads go to all selected axes in the same edge
          for (int a = 0; a < AXES; a++) begin
            if (cmd_axes[a]) begin
              unique case (cmd_code)
                CMD_JERK:      next_st.jerk[a] = word32;
                CMD_DECEL_JRK: next_st.djerk[a] = word32;
                CMD_ACCEL:     next_st.accel[a] = word32;
                CMD_DECEL:     next_st.decel[a] = word32;
                CMD_INIT_SPD:  next_st.isv[a] = word32;
                CMD_DRV_SPD:   next_st.dsv[a] = word32;
                default:       next_st.jerk[a] = st.jerk[a];
              endcase
            end
          end
          // NOP, command reset and unknown codes change nothing here
        end
      endcase
    end
    // Symmetric mode reuses acceleration-side values for deceleration; a mode change shows one cycle later
    for (int a = 0; a < AXES; a++) begin
      next_st.djerk_mux[a] = nonsymmetric_profile_select ? next_st.djerk[a] : next_st.jerk[a];
      next_st.decel_mux[a] = nonsymmetric_profile_select ? next_st.decel[a] : next_st.accel[a];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.ao <= ACCEL_OFS_RST;
      st.lx <= POS_MAX_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.rdata  = st.rdata;
  assign bus.rvalid = st.rvalid;
  assign speed_inc        = st.inc;
  assign speed_dec        = st.dec;
  assign deviation_clear  = st.dev_clr;
  assign timer_run        = st.tmr;
  assign split_run        = st.split;
  assign start_hold       = st.hold;
  assign error_clear      = st.err_clr;
  assign finish_max_clear = st.fp_clr;
  assign status_three_page = st.page;
  assign accel_offset_value = st.ao;
  assign logical_pos_max    = st.lx;

  for (genvar g = 0; g < AXES; g++) begin : g_ax
    assign jerk_value[g]          = st.jerk[g];
    assign decel_jerk_eff[g]      = st.djerk_mux[g];
    assign accel_eff[g]           = st.accel[g];
    assign decel_eff[g]           = st.decel_mux[g];
    assign initial_speed_value[g] = st.isv[g];
    assign target_speed[g]        = st.dsv[g];
    assign current_speed[g]       = st.cur[g];
  end
endmodule : mpw_device
`default_nettype wire

// ===== rtl/mpw_host.sv
`timescale 1ns/1ps
`default_nettype none
module mpw_host
  import mpw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  mpw_if.host                    bus,
  input  wire logic              req,
  input  wire logic              req_wide,
  input  wire logic [31:0]       req_data,
  input  wire logic [3:0]        req_axes,
  input  wire logic [7:0]        req_code,
  output logic                   busy,
  output logic [31:0]            rd_data,
  output logic                   rd_valid
);
  typedef enum logic [1:0] {H_IDLE, H_HIGH, H_LOW, H_CMD} mpw_hst_t;
  typedef struct packed {
    mpw_hst_t    state;
    logic [31:0] data;
    logic [11:0] cmd;
    logic        wide;
    logic [3:0]  wait_cnt;
    logic        wr;
    mpw_sel_t    sel;
    logic [15:0] wdata;
    logic [31:0] rd;
    logic        rv;
    logic        busy;
  } mpw_host_st_t;

  mpw_host_st_t st;
  mpw_host_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.rv = bus.rvalid;
    if (bus.rvalid) begin
      next_st.rd = bus.rdata;
    end
    if (st.wait_cnt != 4'h0) begin
      next_st.wait_cnt = st.wait_cnt - 4'h1;
    end
    unique case (st.state)
      H_IDLE: begin
        next_st.busy = st.wait_cnt > 4'h1;
        if (req && st.wait_cnt == 4'h0) begin
          next_st.data = req_data;
          next_st.cmd  = {req_axes, req_code};
          next_st.wide = req_wide;
          next_st.busy = 1'b1;
          next_st.state = req_wide ? H_HIGH : H_LOW;
        end
      end
      H_HIGH: begin
        next_st.wr = 1'b1;
        next_st.sel = MPW_SEL_HIGH;
        next_st.wdata = st.data[31:16];
        next_st.state = H_LOW;
      end
      H_LOW: begin
        next_st.wr = 1'b1;
        next_st.sel = MPW_SEL_LOW;
        next_st.wdata = st.data[15:0];
        next_st.state = H_CMD;
      end
      H_CMD: begin
        next_st.wr = 1'b1;
        next_st.sel = MPW_SEL_CMD;
        next_st.wdata = {4'h0, st.cmd};
        next_st.wait_cnt = 4'(HOLDOFF_CYCLES);
        next_st.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.wr    = st.wr;
  assign bus.sel   = st.sel;
  assign bus.wdata = st.wdata;
  assign busy      = st.busy;
  assign rd_data   = st.rd;
  assign rd_valid  = st.rv;
endmodule : mpw_host
`default_nettype wire

// ===== tb/mpw_props.sv
`timescale 1ns/1ps
`default_nettype none
module mpw_props
  import mpw_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              wr,
  input wire mpw_sel_t          sel,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid
);
  logic cmd;
  logic rd;
  assign cmd = wr && sel == MPW_SEL_CMD;
  assign rd  = cmd && wdata[7:0] inside {CMD_RD_AC, CMD_RD_SV, CMD_RD_CUR_AC};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Thirteen quiet cycles cover the 125 ns gap at this clock
  property p_holdoff;
    cmd |=> !wr [*8] ##1 !wr [*5];
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("bus written during command hold-off");
  property p_high_low;
    wr && sel == MPW_SEL_HIGH |=> wr && sel == MPW_SEL_LOW;
  endproperty
  a_high_low: assert property (p_high_low)
    else $error("high word not followed by low word");
  property p_low_cmd;
    wr && sel == MPW_SEL_LOW |=> cmd;
  endproperty
  a_low_cmd: assert property (p_low_cmd)
    else $error("low word not followed by command");
  property p_read_ans;
    rd |=> rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read command got no answer");
  property p_ans_cause;
    rvalid |-> $past(rd);
  endproperty
  a_ans_cause: assert property (p_ans_cause)
    else $error("answer without read command");
  property p_ans_pulse;
    rvalid |=> !rvalid [*8];
  endproperty
  a_ans_pulse: assert property (p_ans_pulse)
    else $error("answer longer than one cycle");
  property p_other_quiet;
    cmd && !rd |=> !rvalid [*2];
  endproperty
  a_other_quiet: assert property (p_other_quiet)
    else $error("non-read command answered");
  property p_sel_legal;
    wr |-> sel inside {MPW_SEL_LOW, MPW_SEL_HIGH, MPW_SEL_CMD};
  endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("write to undefined register");
endmodule : mpw_props
`default_nettype wire

// ===== tb/test_motion_param_command_writer.sv
`timescale 1ns/1ps
`default_nettype none
module test_motion_param_command_writer;
  import mpw_pkg::*;
  logic        clk, rst_n, req, req_wide, nsym, busy, rd_valid, page, e_p;
  logic [31:0] req_data, rd_data, seed, r, aofs, pmax;
  logic [31:0] v [6];
  logic [31:0] jerk [4], djr [4], acc [4], dcl [4], spd0 [4], tgt [4], cur [4];
  logic [3:0]  req_axes, drv, ax, inc, dec, dev, tmr, spl, hld, err, fpc, e_t, e_s, e_h;
  logic [7:0]  req_code, c8;
  logic [19:0] seen, e_seen;
  logic [31:0] rq [$];
  int          bad_count, checks_done;

  mpw_if u_bus ();
  mpw_host i_mpw_host (.clk(clk), .rst_n(rst_n), .bus(u_bus.host), .req(req), .req_wide(req_wide),
    .req_data(req_data), .req_axes(req_axes), .req_code(req_code), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid));
  mpw_device i_mpw_device (.clk(clk), .rst_n(rst_n), .bus(u_bus.dev), .nonsymmetric_profile_select(nsym),
    .driving(drv), .speed_inc(inc), .speed_dec(dec), .deviation_clear(dev), .timer_run(tmr),
    .split_run(spl), .start_hold(hld), .error_clear(err), .finish_max_clear(fpc),
    .status_three_page(page), .jerk_value(jerk), .decel_jerk_eff(djr), .accel_eff(acc), .decel_eff(dcl),
    .initial_speed_value(spd0), .target_speed(tgt), .current_speed(cur), .accel_offset_value(aofs),
    .logical_pos_max(pmax));
  mpw_props u_props (.clk(clk), .rst_n(rst_n), .wr(u_bus.wr), .sel(u_bus.sel), .wdata(u_bus.wdata),
    .rdata(u_bus.rdata), .rvalid(u_bus.rvalid));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic send(input logic w, input logic [31:0] d, input logic [3:0] a, input logic [7:0] c);
    int k;
    req = 1'b1;
    req_wide = w;
    req_data = d;
    req_axes = a;
    req_code = c;
    tick(1);
    req = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 60) begin
      tick(1);
      k++;
    end
    if (k == 60) begin
      bad_count++;
      end_sim();
    end
  endtask : send

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses last one cycle, so they are gathered here rather than polled
  always @(negedge clk) begin
    seen |= {inc, dec, dev, err, fpc};
    if (rd_valid === 1'b1) begin
      if (rq.size() > 0) chk({32'h0, rd_data}, {32'h0, rq.pop_front()});
      else chk(64'h1, 64'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    seed = 32'h75f5;
    {rst_n, req, req_wide, req_data, req_axes, req_code, nsym, drv, seen} = '0;
    {e_seen, e_t, e_s, e_h, e_p} = '0;
    tick(2);
    rst_n = 1'b1;
    chk({aofs, pmax}, {32'h8, 32'hffffffff});
    chk({tmr, spl, hld, page}, 64'h0);
    r = rnd();
    // Axis 3 stays unselected so stray loads show up
    ax = {1'b0, r[2:1], 1'b1};
    for (int c = 0; c < 6; c++) begin
      v[c] = (rnd() & 32'h003fffff) | 32'h1;
      send(1'b1, v[c], ax, CMD_JERK + 8'(c));
    end
    for (int n = 0; n < 2; n++) begin
      nsym = n[0];
      tick(1);
      for (int a = 0; a < 4; a++) begin
        chk({jerk[a], spd0[a]}, ax[a] ? {v[0], v[4]} : 64'h0);
        chk({tgt[a], acc[a]}, ax[a] ? {v[5], v[2]} : 64'h0);
        chk({djr[a], dcl[a]}, !ax[a] ? 64'h0 : n ? {v[1], v[3]} : {v[0], v[2]});
      end
    end
    rq.push_back(v[2]);
    send(1'b0, 32'h0, ax, CMD_RD_AC);
    rq.push_back(v[4]);
    send(1'b0, 32'h0, ax, CMD_RD_SV);
    send(1'b1, 32'h00030005, 4'h1, CMD_JERK);
    send(1'b0, 32'h00001234, 4'h1, CMD_JERK);
    chk({32'h0, jerk[0]}, 64'h00031234);
    send(1'b1, 32'd10000, 4'h1, CMD_ACCEL);
    send(1'b1, 32'd100, 4'h1, CMD_INIT_SPD);
    send(1'b1, 32'd110, 4'h1, CMD_DRV_SPD);
    drv = 4'h1;
    tick(30);
    chk({32'h0, cur[0]}, 64'd110);
    send(1'b1, 32'd50, 4'h1, CMD_DRV_SPD);
    tick(30);
    chk({32'h0, cur[0]}, 64'd100);
    send(1'b1, 32'd105, 4'h1, CMD_DRV_SPD);
    tick(30);
    chk({32'h0, cur[0]}, 64'd105);
    rq.push_back(32'h0);
    send(1'b0, 32'h0, 4'h1, CMD_RD_CUR_AC);
    send(1'b1, 32'd1000, 4'h1, CMD_DRV_SPD);
    rq.push_back(32'd10000);
    send(1'b0, 32'h0, 4'h1, CMD_RD_CUR_AC);
    send(1'b1, 32'd105, 4'h1, CMD_DRV_SPD);
    rq.push_back(v[3]);
    send(1'b0, 32'h0, 4'h1, CMD_RD_CUR_AC);
    tick(60);
    chk({32'h0, cur[0]}, 64'd105);
    drv = 4'h0;
    tick(10);
    chk({32'h0, cur[0]}, 64'd100);
    for (int i = 0; i < 15; i++) begin
      c8 = (i < 13) ? 8'h70 + 8'(i) : (i == 13) ? CMD_NOP : CMD_RESET;
      r = rnd();
      ax = r[3:0] | 4'h1;
      e_seen = '0;
      case (c8)
        CMD_SPD_INC:   e_seen[19:16] = ax;
        CMD_SPD_DEC:   e_seen[15:12] = ax;
        CMD_DEV_CLR:   e_seen[11:8] = ax;
        CMD_ERR_CLR:   e_seen[7:4] = ax;
        CMD_FP_CLR:    e_seen[3:0] = ax;
        CMD_TMR_START: e_t |= ax;
        CMD_TMR_STOP:  e_t &= ~ax;
        CMD_SPLIT_ON:  e_s |= ax;
        CMD_SPLIT_OFF: e_s &= ~ax;
        CMD_HOLD:      e_h |= ax;
        CMD_HOLD_REL:  e_h &= ~ax;
        CMD_PAGE0:     e_p = 1'b0;
        CMD_PAGE1:     e_p = 1'b1;
        default:       e_p = e_p;
      endcase
      seen = '0;
      send(1'b0, r, ax, c8);
      chk({seen, tmr, spl, hld, page}, {e_seen, e_t, e_s, e_h, e_p});
    end
    rq.push_back(ACCEL_MAX);
    send(1'b1, ACCEL_MAX, 4'h1, CMD_ACCEL);
    send(1'b0, 32'h0, 4'h1, CMD_RD_AC);
    chk(rq.size(), 64'h0);
    end_sim();
  end
endmodule : test_motion_param_command_writer
`default_nettype wire
